// [sct_consts.vh]
`ifndef SCT_CONSTS_VH
`define SCT_CONSTS_VH

// register offsets
`define SCT_ADDR_CTRL        5'h00
`define SCT_ADDR_SYNC        5'h01
`define SCT_ADDR_IEN         5'h02
`define SCT_ADDR_IFLAG       5'h03
`define SCT_ADDR_LATCH       5'h04
`define SCT_ADDR_HALT        5'h05
`define SCT_ADDR_RSVD0       5'h06
`define SCT_ADDR_SRCSEL      5'h07
`define SCT_ADDR_CNT_LO      5'h08
`define SCT_ADDR_CNT_HI      5'h09
`define SCT_ADDR_TOP_LO      5'h0A
`define SCT_ADDR_TOP_HI      5'h0B
`define SCT_ADDR_MATCH_LO    5'h0C
`define SCT_ADDR_MATCH_HI    5'h0D
`define SCT_ADDR_RSVD1       5'h0E
`define SCT_ADDR_RSVD2       5'h0F
`define SCT_ADDR_TICK_CTRL   5'h10
`define SCT_ADDR_TICK_SYNC   5'h11
`define SCT_ADDR_TICK_IEN    5'h12
`define SCT_ADDR_TICK_IFLAG  5'h13
`define SCT_ADDR_RSVD3       5'h14
`define SCT_ADDR_TICK_HALT   5'h15

// field positions
`define SCT_CTRL_ON          0
`define SCT_CTRL_PRESC_LO    3
`define SCT_CTRL_PRESC_HI    6
`define SCT_CTRL_STBY        7
`define SCT_TICK_ON          0
`define SCT_TICK_PER_LO      3
`define SCT_TICK_PER_HI      6
`define SCT_IRQ_WRAP         0
`define SCT_IRQ_MATCH        1
`define SCT_HALT_RUN         0

// pending slots
`define SCT_PEND_CTRL        0
`define SCT_PEND_CNT         1
`define SCT_PEND_TOP         2
`define SCT_PEND_MATCH       3
`define SCT_PEND_TICK        4

// reset values
`define SCT_RST_BYTE         8'h00
`define SCT_RST_CNT          16'h0000
`define SCT_RST_TOP          16'hFFFF
`define SCT_RST_MATCH        16'h0000

// timing counts
`define SCT_SYNC_SLOW_CYCLES 2'h2
`define SCT_TICK_SEL_MIN     4'h1
`define SCT_TICK_SEL_MAX     4'hE

`endif

// [sct_slow_counter.v]
// Local design decision: the plain strobed port.
`include "sct_consts.vh"
`default_nettype none

module sct_slow_counter #(
  parameter AW = 5,
  parameter DW = 8
) (
  input  wire          clock,
  input  wire          rstn,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  input  wire          wr,
  input  wire          rd,
  output reg  [DW-1:0] rdata,
  input  wire          slow_clk,
  input  wire          sleep_standby,
  input  wire          cpu_halted,
  output reg           irq_counter,
  output reg           irq_tick,
  output reg  [1:0]    source_sel
);

////////////////////////////////////////////////////////////////////////////////
// slow clock edge detection

  reg         slow_s1;
  reg         slow_s2;
  reg         slow_s3;
  wire        slow_edge;

  // first stage only feeds the second; edge taken from the later pair
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      slow_s1 <= 1'b0;
      slow_s2 <= 1'b0;
      slow_s3 <= 1'b0;
    end else begin
      slow_s1 <= slow_clk;
      slow_s2 <= slow_s1;
      slow_s3 <= slow_s2;
    end
  end

  assign slow_edge = slow_s2 & ~slow_s3;

////////////////////////////////////////////////////////////////////////////////
// bus side registers

  reg  [7:0]  ctrl_sh;
  reg  [7:0]  ctrl_live;
  reg  [15:0] cnt_sh;
  reg  [15:0] top_sh;
  reg  [15:0] top_live;
  reg  [15:0] match_sh;
  reg  [15:0] match_live;
  reg  [7:0]  tick_sh;
  reg  [7:0]  tick_live;
  reg  [1:0]  ien;
  reg         tick_ien;
  reg  [7:0]  latch;
  reg         halt_run;
  reg         tick_halt_run;

  wire        wr_ctrl   = wr && (addr == `SCT_ADDR_CTRL);
  wire        wr_cnt    = wr && (addr == `SCT_ADDR_CNT_HI);
  wire        wr_top    = wr && (addr == `SCT_ADDR_TOP_HI);
  wire        wr_match  = wr && (addr == `SCT_ADDR_MATCH_HI);
  wire        wr_tick   = wr && (addr == `SCT_ADDR_TICK_CTRL);
  // low byte writes park in the latch; the high byte write commits both
  wire        wr_lo     = wr && ((addr == `SCT_ADDR_CNT_LO) || (addr == `SCT_ADDR_TOP_LO) ||
                                 (addr == `SCT_ADDR_MATCH_LO) || (addr == `SCT_ADDR_LATCH));

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_sh       <= `SCT_RST_BYTE;
      cnt_sh        <= `SCT_RST_CNT;
      top_sh        <= `SCT_RST_TOP;
      match_sh      <= `SCT_RST_MATCH;
      tick_sh       <= `SCT_RST_BYTE;
      ien           <= 2'b00;
      tick_ien      <= 1'b0;
      halt_run      <= 1'b0;
      tick_halt_run <= 1'b0;
      source_sel    <= 2'b00;
    end else if (wr) begin
      // interrupt enable, halt and source bits live only on the bus side, so they act at once
      case (addr)
        `SCT_ADDR_CTRL: begin
          ctrl_sh <= wdata;
        end
        `SCT_ADDR_IEN: begin
          ien <= wdata[1:0];
        end
        `SCT_ADDR_HALT: begin
          halt_run <= wdata[`SCT_HALT_RUN];
        end
        `SCT_ADDR_SRCSEL: begin
          source_sel <= wdata[1:0];
        end
        `SCT_ADDR_CNT_HI: begin
          cnt_sh <= {wdata, latch};
        end
        `SCT_ADDR_TOP_HI: begin
          top_sh <= {wdata, latch};
        end
        `SCT_ADDR_MATCH_HI: begin
          match_sh <= {wdata, latch};
        end
        `SCT_ADDR_TICK_CTRL: begin
          tick_sh <= wdata;
        end
        `SCT_ADDR_TICK_IEN: begin
          tick_ien <= wdata[0];
        end
        `SCT_ADDR_TICK_HALT: begin
          tick_halt_run <= wdata[`SCT_HALT_RUN];
        end
        default: begin
        end
      endcase
    end
  end

////////////////////////////////////////////////////////////////////////////////
// crossing into the slow side: each control, tick control or high byte write waits two slow edges

  // the slow side never sees a half-written pair: only the high byte starts a wait
  wire [4:0]  pend_start = {wr_tick, wr_match, wr_top, wr_cnt, wr_ctrl};
  wire [4:0]  pend_busy;
  wire [4:0]  pend_apply;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_pend
      reg [1:0] pend_cnt;
      // a fresh write restarts the wait; software is expected to poll first
      always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          pend_cnt <= 2'b00;
        end else if (pend_start[gi]) begin
          pend_cnt <= `SCT_SYNC_SLOW_CYCLES;
        end else if (slow_edge && (pend_cnt != 2'b00)) begin
          pend_cnt <= pend_cnt - 2'b01;
        end
      end
      assign pend_busy[gi]  = (pend_cnt != 2'b00);
      assign pend_apply[gi] = slow_edge && (pend_cnt == 2'b01) && !pend_start[gi];
    end
  endgenerate

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_live  <= `SCT_RST_BYTE;
      top_live   <= `SCT_RST_TOP;
      match_live <= `SCT_RST_MATCH;
      tick_live  <= `SCT_RST_BYTE;
    end else begin
      if (pend_apply[`SCT_PEND_CTRL]) begin
        ctrl_live <= ctrl_sh;
      end
      if (pend_apply[`SCT_PEND_TOP]) begin
        top_live <= top_sh;
      end
      if (pend_apply[`SCT_PEND_MATCH]) begin
        match_live <= match_sh;
      end
      if (pend_apply[`SCT_PEND_TICK]) begin
        tick_live <= tick_sh;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
// counter with prescaler

  reg  [14:0] presc_cnt;
  reg  [15:0] count;
  wire [3:0]  presc_sel  = ctrl_live[`SCT_CTRL_PRESC_HI:`SCT_CTRL_PRESC_LO];
  wire [14:0] presc_mask = ~(15'h7FFF << presc_sel);
  // idle sleep needs nothing; standby and debug halt are the only stops
  wire        cnt_run    = ctrl_live[`SCT_CTRL_ON]
                           && !(sleep_standby && !ctrl_live[`SCT_CTRL_STBY])
                           && !(cpu_halted && !halt_run);
  wire        cnt_step   = cnt_run && slow_edge && ((presc_cnt & presc_mask) == presc_mask);
  wire        ev_wrap    = cnt_step && (count == top_live);
  wire        ev_match   = cnt_step && (count == match_live);

  // prescaler restarts from zero whenever the counter is switched off
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      presc_cnt <= 15'h0000;
    end else if (!ctrl_live[`SCT_CTRL_ON]) begin
      presc_cnt <= 15'h0000;
    end else if (cnt_run && slow_edge) begin
      presc_cnt <= presc_cnt + 15'h0001;
    end
  end

  // a pending count load wins over a step in the same cycle
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= `SCT_RST_CNT;
    end else if (pend_apply[`SCT_PEND_CNT]) begin
      count <= cnt_sh;
    end else if (ev_wrap) begin
      count <= 16'h0000;
    end else if (cnt_step) begin
      count <= count + 16'h0001;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// periodic tick unit

  reg  [14:0] tick_div;
  wire [3:0]  tick_sel   = tick_live[`SCT_TICK_PER_HI:`SCT_TICK_PER_LO];
  wire [4:0]  tick_shift = {1'b0, tick_sel} + 5'h01;
  wire [14:0] tick_mask  = ~(15'h7FFF << tick_shift);
  wire        tick_sel_ok = (tick_sel >= `SCT_TICK_SEL_MIN) && (tick_sel <= `SCT_TICK_SEL_MAX);
  // selections 0 and 15 stay silent rather than alias another period
  // no standby gate here: the tick unit keeps going in every sleep mode
  wire        tick_run   = tick_live[`SCT_TICK_ON] && !(cpu_halted && !tick_halt_run);
  wire        ev_tick    = tick_run && slow_edge && tick_sel_ok &&
                           ((tick_div & tick_mask) == tick_mask);

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tick_div <= 15'h0000;
    end else if (!tick_live[`SCT_TICK_ON]) begin
      tick_div <= 15'h0000;
    end else if (tick_run && slow_edge) begin
      tick_div <= tick_div + 15'h0001;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// flags and interrupt requests

  reg  [1:0]  flags;
  reg         tick_flag;
  wire [1:0]  flag_clr   = (wr && (addr == `SCT_ADDR_IFLAG)) ? wdata[1:0] : 2'b00;
  wire        tick_clr   = wr && (addr == `SCT_ADDR_TICK_IFLAG) && wdata[0];
  wire [1:0]  flag_set   = {ev_match, ev_wrap};
  wire [1:0]  next_flags = (flags & ~flag_clr) | flag_set;
  wire        next_tick_flag = (tick_flag & ~tick_clr) | ev_tick;

  // set wins over a clear arriving in the same cycle
  // a flag clear reaches the request at once; an enable write lands a cycle later
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flags       <= 2'b00;
      tick_flag   <= 1'b0;
      irq_counter <= 1'b0;
      irq_tick    <= 1'b0;
    end else begin
      flags       <= next_flags;
      tick_flag   <= next_tick_flag;
      irq_counter <= |(next_flags & ien);
      irq_tick    <= next_tick_flag & tick_ien;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// read path and the shared byte latch

  reg  [7:0]  next_rdata;
  reg  [7:0]  next_latch;

  // reading a low byte grabs the matching high byte so a two-read pair is coherent
  always @* begin
    next_rdata = 8'h00;
    next_latch = latch;
    if (wr_lo) begin
      next_latch = wdata;
    end
    if (rd) begin
      // sync state bits come straight from the pending counters, no extra stage
      case (addr)
        `SCT_ADDR_CTRL: begin
          next_rdata = ctrl_live;
        end
        `SCT_ADDR_SYNC: begin
          next_rdata = {4'h0, pend_busy[3:0]};
        end
        `SCT_ADDR_IEN: begin
          next_rdata = {6'h00, ien};
        end
        `SCT_ADDR_IFLAG: begin
          next_rdata = {6'h00, flags};
        end
        `SCT_ADDR_LATCH: begin
          next_rdata = latch;
        end
        `SCT_ADDR_HALT: begin
          next_rdata = {7'h00, halt_run};
        end
        `SCT_ADDR_SRCSEL: begin
          next_rdata = {6'h00, source_sel};
        end
        `SCT_ADDR_CNT_LO: begin
          next_rdata = count[7:0];
          next_latch = count[15:8];
        end
        `SCT_ADDR_TOP_LO: begin
          next_rdata = top_live[7:0];
          next_latch = top_live[15:8];
        end
        `SCT_ADDR_MATCH_LO: begin
          next_rdata = match_live[7:0];
          next_latch = match_live[15:8];
        end
        `SCT_ADDR_CNT_HI,
        `SCT_ADDR_TOP_HI,
        `SCT_ADDR_MATCH_HI: begin
          next_rdata = latch;
        end
        `SCT_ADDR_TICK_CTRL: begin
          next_rdata = tick_live;
        end
        `SCT_ADDR_TICK_SYNC: begin
          next_rdata = {7'h00, pend_busy[`SCT_PEND_TICK]};
        end
        `SCT_ADDR_TICK_IEN: begin
          next_rdata = {7'h00, tick_ien};
        end
        `SCT_ADDR_TICK_IFLAG: begin
          next_rdata = {7'h00, tick_flag};
        end
        `SCT_ADDR_TICK_HALT: begin
          next_rdata = {7'h00, tick_halt_run};
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
      latch <= `SCT_RST_BYTE;
    end else begin
      rdata <= next_rdata;
      latch <= next_latch;
    end
  end

endmodule // sct_slow_counter

`default_nettype wire

// [sct_slow_counter_assertions.sv]
`default_nettype none
module sct_slow_counter_assertions (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       slow_clk,
  input wire logic       sleep_standby,
  input wire logic       cpu_halted,
  input wire logic       irq_counter,
  input wire logic       irq_tick,
  input wire logic [1:0] source_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  logic rsvd;
  assign rsvd = addr == 5'h06 || addr == 5'h0e || addr == 5'h0f || addr == 5'h14 || addr > 5'h15;
  a_rsvd_read_zero: assert property (rd && rsvd |=> rdata == 8'h00)
    else $error("reserved offset read nonzero");
  // a flag clear drops the request one cycle on, an enable write two cycles on
  a_wrap_irq_hold: assert property ($fell(irq_counter) |->
    ($past(wr) && $past(addr) == 5'h03) || ($past(wr, 2) && $past(addr, 2) == 5'h02))
    else $error("counter request dropped without a write");
  a_tick_irq_hold: assert property ($fell(irq_tick) |->
    ($past(wr) && $past(addr) == 5'h13) || ($past(wr, 2) && $past(addr, 2) == 5'h12))
    else $error("tick request dropped without a write");
  // a write one cycle earlier may already be on its way to the request line
  a_wrap_zero_keep: assert property (!$past(wr) && wr && addr == 5'h03 &&
    wdata == 8'h00 && irq_counter |-> ##2 irq_counter)
    else $error("writing zero cleared a counter flag");
  a_tick_zero_keep: assert property (!$past(wr) && wr && addr == 5'h13 &&
    wdata == 8'h00 && irq_tick |-> ##2 irq_tick)
    else $error("writing zero cleared the tick flag");
  a_wrap_en_off: assert property (wr && addr == 5'h02 && wdata[1:0] == 2'b00 |->
    ##2 !irq_counter) else $error("counter request with sources disabled");
  a_tick_en_off: assert property (wr && addr == 5'h12 && !wdata[0] |-> ##2 !irq_tick)
    else $error("tick request with source disabled");
  a_top_pend_set: assert property (wr && addr == 5'h0b ##2 rd && addr == 5'h01 |=>
    rdata[2]) else $error("top pending bit not shown");
  a_tick_pend_set: assert property (wr && addr == 5'h10 ##2 rd && addr == 5'h11 |=>
    rdata[0]) else $error("tick pending bit not shown");
  c_wrap_irq: cover property ($rose(irq_counter));
  c_tick_irq: cover property ($rose(irq_tick));
  c_rsvd_read: cover property (rd && rsvd);
endmodule // sct_slow_counter_assertions

bind sct_slow_counter sct_slow_counter_assertions chk_u (.clock(clock), .rstn(rstn),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .slow_clk(slow_clk),
  .sleep_standby(sleep_standby), .cpu_halted(cpu_halted), .irq_counter(irq_counter),
  .irq_tick(irq_tick), .source_sel(source_sel));
`default_nettype wire

// [sct_cpu_model.sv]
`default_nettype none
module sct_cpu_model (
  input  wire logic       clock,
  input  wire logic [7:0] rdata,
  output var  logic [4:0] addr,
  output var  logic [7:0] wdata,
  output var  logic       wr,
  output var  logic       rd
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  initial {addr, wdata, wr, rd} = 15'h0000;
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask
  // polls a sync state register until no write is still crossing
  task automatic wait_idle(input logic [4:0] a, output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 64 && !ok; i++) begin
      bus_rd(a, s);
      ok = (s === 8'h00);
    end
  endtask
endmodule // sct_cpu_model
`default_nettype wire

// [slow_counter_tick_irq_sync_tb_top.sv]
`default_nettype none
module slow_counter_tick_irq_sync_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn, slow_clk, sleep_standby, cpu_halted, wr, rd, ok;
  logic irq_counter, irq_tick;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, v, c0;
  logic [1:0] source_sel;
  logic [7:0] mdl [32];
  logic [4:0] rsv [4] = '{5'h06, 5'h0e, 5'h0f, 5'h14};
  int n_fail, check_count, seed;
  int cycles = 0;
  sct_slow_counter dut_u (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .slow_clk(slow_clk), .sleep_standby(sleep_standby),
    .cpu_halted(cpu_halted), .irq_counter(irq_counter), .irq_tick(irq_tick),
    .source_sel(source_sel));
  sct_cpu_model cpu_u (.clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd));
  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // slow clock at an eighth of the bus clock, inside the quarter-rate limit
  always @(posedge clock) begin
    cycles <= cycles + 1;
    slow_clk <= cycles[2];
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr8(input logic [4:0] a, input logic [7:0] d);
    cpu_u.bus_wr(a, d);
    mdl[a] = d;
  endtask
  task automatic rchk(input logic [4:0] a);
    cpu_u.bus_rd(a, v);
    chk(v, mdl[a]);
  endtask
  task automatic settle(input logic [4:0] a);
    cpu_u.wait_idle(a, ok);
    chk({7'h00, ok}, 8'h01);
  endtask
  initial begin
    {rstn, sleep_standby, cpu_halted} = 3'h0;
    {n_fail, check_count} = '0;
    seed = 32'h3315;
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[10] = 8'hff;
    mdl[11] = 8'hff;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    for (int a = 0; a < 22; a++) rchk(5'(a));
    foreach (rsv[i]) begin
      cpu_u.bus_wr(rsv[i], 8'($random(seed)));
      rchk(rsv[i]);
    end
    wr8(5'h04, 8'($random(seed)));
    rchk(5'h04);
    v = 8'($random(seed));
    cpu_u.bus_wr(5'h07, v);
    mdl[7] = {6'h00, v[1:0]};
    rchk(5'h07);
    chk({6'h00, source_sel}, mdl[7]);
    // top 3 and match 1 give a wrap every four slow edges
    wr8(5'h0a, 8'h03);
    wr8(5'h0b, 8'h00);
    settle(5'h01);
    wr8(5'h0c, 8'h01);
    wr8(5'h0d, 8'h00);
    settle(5'h01);
    wr8(5'h00, 8'h01);
    settle(5'h01);
    repeat (80) @(posedge clock);
    mdl[3] = 8'h03;
    rchk(5'h03);
    chk({7'h00, irq_counter}, 8'h00);
    wr8(5'h02, 8'h01);
    repeat (3) @(posedge clock);
    chk({7'h00, irq_counter}, 8'h01);
    cpu_u.bus_wr(5'h03, 8'h00);
    rchk(5'h03);
    wr8(5'h02, 8'h00);
    repeat (3) @(posedge clock);
    chk({7'h00, irq_counter}, 8'h00);
    wr8(5'h00, 8'h00);
    settle(5'h01);
    repeat (8) @(posedge clock);
    cpu_u.bus_wr(5'h03, 8'h03);
    mdl[3] = 8'h00;
    rchk(5'h03);
    wr8(5'h08, 8'h02);
    wr8(5'h09, 8'h00);
    settle(5'h01);
    rchk(5'h08);
    rchk(5'h09);
    wr8(5'h00, 8'h01);
    settle(5'h01);
    sleep_standby <= 1'b1;
    repeat (16) @(posedge clock);
    cpu_u.bus_rd(5'h08, c0);
    wr8(5'h10, 8'h09);
    settle(5'h11);
    repeat (80) @(posedge clock);
    mdl[8] = c0;
    rchk(5'h08);
    mdl[19] = 8'h01;
    rchk(5'h13);
    chk({7'h00, irq_tick}, 8'h00);
    wr8(5'h12, 8'h01);
    repeat (3) @(posedge clock);
    chk({7'h00, irq_tick}, 8'h01);
    cpu_u.bus_wr(5'h13, 8'h00);
    rchk(5'h13);
    wr8(5'h12, 8'h00);
    repeat (3) @(posedge clock);
    chk({7'h00, irq_tick}, 8'h00);
    wr8(5'h00, 8'h81);
    settle(5'h01);
    cpu_u.bus_rd(5'h08, c0);
    repeat (16) @(posedge clock);
    cpu_u.bus_rd(5'h08, v);
    chk({7'h00, v !== c0}, 8'h01);
    sleep_standby <= 1'b0;
    // idle running needs no standby bit; a halted core freezes the count
    wr8(5'h00, 8'h01);
    settle(5'h01);
    cpu_u.bus_rd(5'h08, c0);
    repeat (16) @(posedge clock);
    cpu_u.bus_rd(5'h08, v);
    chk({7'h00, v !== c0}, 8'h01);
    cpu_halted <= 1'b1;
    repeat (4) @(posedge clock);
    cpu_u.bus_rd(5'h08, c0);
    repeat (16) @(posedge clock);
    cpu_u.bus_rd(5'h08, v);
    chk(v, c0);
    tally_and_finish();
  end
endmodule // slow_counter_tick_irq_sync_tb_top
`default_nettype wire
